/* logic/sdi_pkg.sv */
package sdi_pkg;
  // ---------------------------------------------------------------
  // chain and bytes
  // ---------------------------------------------------------------
  localparam int SDI_MAX_DEVICES = 31;
  localparam int SDI_BYTE_W = 8;
  // command byte fields
  localparam int SDI_CMD_MAGNET = 0;
  localparam int SDI_CMD_FORCE_LO = 1;
  localparam int SDI_CMD_RESET = 7;
  // state report byte fields
  localparam int SDI_RSP_OUT_ON = 0;
  localparam int SDI_RSP_ACTUATOR = 1;
  localparam int SDI_RSP_LOCKED = 2;
  localparam int SDI_RSP_INPUTS = 4;
  localparam int SDI_RSP_WARN = 6;
  localparam int SDI_RSP_ERR = 7;
  // warning and error detail fields
  localparam int SDI_DET_OUT1 = 0;
  localparam int SDI_DET_OUT2 = 1;
  localparam int SDI_DET_CROSS = 2;
  localparam int SDI_DET_TEMP = 3;
  localparam int SDI_DET_FORCE = 4;
  localparam int SDI_DET_INTERNAL = 5;
  localparam int SDI_DET_COMM = 6;
  localparam int SDI_DET_UNDERV = 7;
  localparam logic [7:0] SDI_BYTE_RST = 8'h00;
  localparam logic [7:0] SDI_OUT_FAULT_MASK = 8'h07;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint SDI_CLK_HZ = 40000000;
  localparam longint SDI_WARN_MIN = 30;
  localparam longint SDI_WARN_CYCLES = SDI_WARN_MIN * 64'd60 * SDI_CLK_HZ;
  localparam int SDI_COMM_TIMEOUT_CYCLES = 4000;
  // ---------------------------------------------------------------
  // host register map (wishbone byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] SDI_REG_CMD = 8'h00;
  localparam logic [7:0] SDI_REG_RSP = 8'h04;
  localparam logic [7:0] SDI_REG_WARN = 8'h08;
  localparam logic [7:0] SDI_REG_ERR = 8'h0C;
  localparam logic [7:0] SDI_REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] SDI_REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] SDI_REG_IRQ_EN = 8'h18;
  localparam int SDI_IRQ_W = 3;
  localparam int SDI_IRQ_NEWDATA = 0;
  localparam int SDI_IRQ_WARN = 1;
  localparam int SDI_IRQ_ERR = 2;
endpackage

/* logic/sdi_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// one device slot of the chain: command byte out, three status bytes back
interface sdi_link_if;
  logic [7:0] cmd;
  logic cmd_valid;
  logic [7:0] rsp;
  logic [7:0] warn;
  logic [7:0] err;
  logic rsp_valid;
  modport ctrl (output cmd, output cmd_valid, input rsp, input warn, input err, input rsp_valid);
  modport dev (input cmd, input cmd_valid, output rsp, output warn, output err, output rsp_valid);
endinterface
`default_nettype wire

/* logic/sdi_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage input filter: a change counts once stages two and three agree
module sdi_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_o <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* logic/sdi_device.sv */
`timescale 1ns/1ps
`default_nettype none
module sdi_device
  import sdi_pkg::*;
#(
  parameter bit ACTUATOR_VARIANT = 1'b0,
  parameter longint WARN_CYCLES = sdi_pkg::SDI_WARN_CYCLES,
  parameter int COMM_TIMEOUT = sdi_pkg::SDI_COMM_TIMEOUT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_rst_i,
  sdi_link_if.dev link,
  input wire logic guard_closed_i,
  input wire logic actuator_in_i,
  input wire logic lock_engaged_i,
  input wire logic safety_input_one_i,
  input wire logic safety_input_two_i,
  input wire logic [7:0] warn_cause_i,
  input wire logic [7:0] err_cause_i,
  output logic safety_output_one_o,
  output logic safety_output_two_o,
  output logic magnet_o,
  output logic [2:0] force_sel_o
);
  import sdi_pkg::*;
  // ---------------------------------------------------------------
  // pin filtering
  // ---------------------------------------------------------------
  logic [20:0] raw_w, syn_w;
  assign raw_w = {warn_cause_i, err_cause_i, safety_input_two_i, safety_input_one_i,
                  lock_engaged_i, actuator_in_i, guard_closed_i};
  sdi_sync #(.W(21)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(raw_w),
    .q_o(syn_w)
  );
  logic guard_w, act_w, lock_w, in1_w, in2_w;
  logic [7:0] ecause_w, wcause_w;
  assign guard_w = syn_w[0];
  assign act_w = syn_w[1];
  assign lock_w = syn_w[2];
  assign in1_w = syn_w[3];
  assign in2_w = syn_w[4];
  assign ecause_w = syn_w[12:5];
  assign wcause_w = syn_w[20:13];
  // ---------------------------------------------------------------
  // command intake and link watchdog
  // ---------------------------------------------------------------
  logic [7:0] cmd_q;
  logic reset_prev_q;
  logic [31:0] comm_cnt_q;
  logic comm_lost_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= SDI_BYTE_RST;
      reset_prev_q <= 1'b0;
    end else if (link.cmd_valid) begin
      cmd_q <= link.cmd;
      reset_prev_q <= cmd_q[SDI_CMD_RESET];
    end else begin
      reset_prev_q <= cmd_q[SDI_CMD_RESET];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comm_cnt_q <= '0;
      comm_lost_q <= 1'b0;
    end else if (link.cmd_valid) begin
      comm_cnt_q <= '0;
      comm_lost_q <= 1'b0;
    end else if (comm_cnt_q >= 32'(COMM_TIMEOUT)) begin
      comm_lost_q <= 1'b1;
    end else begin
      comm_cnt_q <= comm_cnt_q + 32'd1;
    end
  end
  logic reset_fall_w;
  assign reset_fall_w = reset_prev_q & ~cmd_q[SDI_CMD_RESET];
  // ---------------------------------------------------------------
  // error latch
  // ---------------------------------------------------------------
  logic [7:0] err_q;
  logic multi_lock_q;
  logic warn_expired_q;
  logic [63:0] warn_cnt_q;
  logic out_on_q;
  logic release_w;
  logic [7:0] err_set_w, keep_out_w;
  assign err_set_w = ecause_w | (warn_expired_q ? wcause_w : 8'h00);
  // output faults survive until outputs are released again
  assign keep_out_w = err_q & SDI_OUT_FAULT_MASK & {8{~release_w}};
  always_ff @(posedge clk_i) begin
    if (power_on_rst_i) begin
      err_q <= SDI_BYTE_RST;
    end else if (reset_fall_w || !guard_w) begin
      err_q <= err_set_w | keep_out_w; // set wins over clear
    end else begin
      err_q <= err_q | err_set_w;
    end
  end
  // only a power cycle clears a multiple output fault, not rst_i
  always_ff @(posedge clk_i) begin
    if (power_on_rst_i) begin
      multi_lock_q <= 1'b0;
    end else if ((ecause_w[SDI_DET_OUT1] && ecause_w[SDI_DET_OUT2]) ||
                 (wcause_w[SDI_DET_OUT1] && wcause_w[SDI_DET_OUT2])) begin
      multi_lock_q <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // warning timer: longint width covers 30 min at 40 MHz
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || wcause_w == 8'h00) begin
      warn_cnt_q <= '0;
      warn_expired_q <= 1'b0;
    end else if (warn_cnt_q >= 64'(WARN_CYCLES - 1)) begin
      warn_expired_q <= 1'b1;
    end else begin
      warn_cnt_q <= warn_cnt_q + 64'd1;
    end
  end
  // ---------------------------------------------------------------
  // safety outputs and actuators
  // ---------------------------------------------------------------
  logic enable_w, any_err_w, ready_w;
  assign any_err_w = (err_q != 8'h00) || multi_lock_q;
  // ready ignores the latch, else a latched output fault could never see a release
  assign ready_w = guard_w && act_w && in1_w && in2_w && !multi_lock_q &&
                   (lock_w || ACTUATOR_VARIANT);
  assign enable_w = ready_w && !any_err_w;
  assign release_w = ready_w && !out_on_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_on_q <= 1'b0;
      magnet_o <= 1'b0;
      force_sel_o <= 3'h0;
    end else if (!comm_lost_q || any_err_w) begin
      out_on_q <= enable_w; // frozen while link is lost, unless an error is latched
      magnet_o <= cmd_q[SDI_CMD_MAGNET];
      force_sel_o <= cmd_q[SDI_CMD_FORCE_LO +: 3];
    end
  end
  assign safety_output_one_o = out_on_q;
  assign safety_output_two_o = out_on_q;
  // ---------------------------------------------------------------
  // status bytes, all active high
  // ---------------------------------------------------------------
  logic [7:0] rsp_q, warn_q, errb_q;
  logic rsp_valid_q;
  logic [7:0] wdet_w, edet_w;
  always_comb begin
    wdet_w = wcause_w;
    wdet_w[SDI_DET_COMM] = comm_lost_q;
    edet_w = err_q;
    if (ACTUATOR_VARIANT) begin
      edet_w[SDI_DET_COMM] = 1'b0;
    end
    if (multi_lock_q) begin
      edet_w[SDI_DET_CROSS] = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_q <= SDI_BYTE_RST;
      warn_q <= SDI_BYTE_RST;
      errb_q <= SDI_BYTE_RST;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_q <= 8'h00;
      rsp_q[SDI_RSP_OUT_ON] <= out_on_q;
      rsp_q[SDI_RSP_ACTUATOR] <= guard_w && act_w;
      rsp_q[SDI_RSP_LOCKED] <= lock_w;
      rsp_q[SDI_RSP_INPUTS] <= in1_w && in2_w;
      rsp_q[SDI_RSP_WARN] <= (wdet_w != 8'h00) && !any_err_w;
      rsp_q[SDI_RSP_ERR] <= any_err_w;
      warn_q <= wdet_w;
      errb_q <= edet_w;
      rsp_valid_q <= 1'b1;
    end
  end
  assign link.rsp = rsp_q;
  assign link.warn = warn_q;
  assign link.err = errb_q;
  assign link.rsp_valid = rsp_valid_q;
endmodule
`default_nettype wire

/* logic/sdi_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// gateway end: wishbone slave holding one slot's command and status copy
module sdi_ctrl
  import sdi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  sdi_link_if.ctrl link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);
  import sdi_pkg::*;
  // ---------------------------------------------------------------
  // bus slave, one wait state
  // ---------------------------------------------------------------
  logic [7:0] cmd_q, rsp_q, warn_q, err_q;
  logic cmd_valid_q;
  logic [SDI_IRQ_W-1:0] stat_q, en_q, ev_w, clr_w;
  logic req_w, wr_w;
  assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_w = req_w && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= '0;
      if (req_w && !wb_we_i) begin
        if (wb_adr_i == SDI_REG_RSP) begin
          wb_dat_o <= {24'h0, rsp_q};
        end else if (wb_adr_i == SDI_REG_WARN) begin
          wb_dat_o <= {24'h0, warn_q};
        end else if (wb_adr_i == SDI_REG_ERR) begin
          wb_dat_o <= {24'h0, err_q};
        end else if (wb_adr_i == SDI_REG_IRQ_STAT) begin
          wb_dat_o <= {29'h0, stat_q};
        end else if (wb_adr_i == SDI_REG_IRQ_EN) begin
          wb_dat_o <= {29'h0, en_q};
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // command byte: re-sent every cycle so the device sees a live link
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= SDI_BYTE_RST;
      cmd_valid_q <= 1'b0;
      en_q <= '0;
    end else begin
      cmd_valid_q <= 1'b1;
      if (wr_w && wb_adr_i == SDI_REG_CMD) begin
        cmd_q <= wb_dat_i[7:0];
      end
      if (wr_w && wb_adr_i == SDI_REG_IRQ_EN) begin
        en_q <= wb_dat_i[SDI_IRQ_W-1:0];
      end
    end
  end
  assign link.cmd = cmd_q;
  assign link.cmd_valid = cmd_valid_q;
  // ---------------------------------------------------------------
  // status copy and interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_q <= SDI_BYTE_RST;
      warn_q <= SDI_BYTE_RST;
      err_q <= SDI_BYTE_RST;
    end else if (link.rsp_valid) begin
      rsp_q <= link.rsp;
      warn_q <= link.warn;
      err_q <= link.err;
    end
  end
  assign ev_w[SDI_IRQ_NEWDATA] = link.rsp_valid && (link.rsp != rsp_q);
  assign ev_w[SDI_IRQ_WARN] = link.rsp_valid && link.rsp[SDI_RSP_WARN] && !rsp_q[SDI_RSP_WARN];
  assign ev_w[SDI_IRQ_ERR] = link.rsp_valid && link.rsp[SDI_RSP_ERR] && !rsp_q[SDI_RSP_ERR];
  assign clr_w = (wr_w && wb_adr_i == SDI_REG_IRQ_CLR) ? wb_dat_i[SDI_IRQ_W-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
      irq_o <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr_w) | ev_w;
      irq_o <= (((stat_q & ~clr_w) | ev_w) & en_q) != '0;
    end
  end
endmodule
`default_nettype wire

/* tb/sdi_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sdi_assertions #(
  parameter int WARN_CYCLES = 50
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] cmd,
  input wire logic cmd_valid,
  input wire logic [7:0] rsp,
  input wire logic [7:0] warn,
  input wire logic [7:0] err,
  input wire logic rsp_valid
);
  // -------------------------------------------------------------
  // warning age, counted while the report shows a warning
  // -------------------------------------------------------------
  int warn_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !rsp[6]) begin
      warn_cnt_q <= 0;
    end else begin
      warn_cnt_q <= warn_cnt_q + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  rsp_alive_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> rsp_valid)
    else $error("status valid dropped");
  cmd_alive_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> cmd_valid)
    else $error("command valid dropped");
  err_outs_off_a: assert property (rsp[7] && $past(rsp[7], 2) |-> !rsp[0])
    else $error("outputs on during error");
  warn_vs_err_a: assert property (rsp[7] |-> !rsp[6])
    else $error("warning shown with error");
  warn_detail_a: assert property ($rose(rsp[6]) |-> ##[0:1] warn != 8'h00)
    else $error("warning without detail");
  err_detail_a: assert property ($rose(rsp[7]) |-> ##[0:1] err != 8'h00)
    else $error("error without detail");
  // filter and report stages add a few cycles around the timer
  warn_timer_a: assert property (warn_cnt_q <= WARN_CYCLES + 8)
    else $error("warning outlived its timer");
  warn_early_a: assert property ($fell(rsp[6]) && rsp[7] |-> $past(warn_cnt_q) >= WARN_CYCLES - 8)
    else $error("warning escalated early");
  warn_clear_a: assert property ($fell(|warn) |-> ##[0:2] !rsp[6])
    else $error("warning kept after cause");
  guard_drop_a: assert property ($fell(rsp[1]) |-> ##[0:2] !rsp[0])
    else $error("outputs on without actuator");
  cover property (rsp == 8'h17);
  cover property ($rose(rsp[6]));
  cover property ($rose(rsp[7]));
endmodule
`default_nettype wire

/* tb/serial_diag_interlock_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_diag_interlock_status_tb_top;
  import sdi_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por = 1'b1;
  logic guard = 1'b0;
  logic act = 1'b0;
  logic lock = 1'b0;
  logic in1 = 1'b0;
  logic in2 = 1'b0;
  logic [7:0] wcause = 8'h00;
  logic [7:0] ecause = 8'h00;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic so1;
  logic so2;
  logic mag;
  logic [2:0] fsel;
  logic vso1;
  logic vso2;
  logic [7:0] q;
  int mismatches = 0;
  int tests_run = 0;
  int wd = 0;
  always #12.5 clk_i = ~clk_i;
  // one slot of a chain that holds at most SDI_MAX_DEVICES slots
  sdi_link_if sdi_link_if_i();
  sdi_ctrl sdi_ctrl_i(.clk_i(clk_i), .rst_i(rst_i), .link(sdi_link_if_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));
  // actuator-monitored slot on a link of its own; its bus stays idle
  sdi_link_if sdi_link_if_var_i();
  sdi_ctrl sdi_ctrl_var_i(.clk_i(clk_i), .rst_i(rst_i), .link(sdi_link_if_var_i),
    .wb_cyc_i(1'b0), .wb_stb_i(1'b0), .wb_we_i(1'b0), .wb_adr_i(8'h00), .wb_sel_i(4'h0),
    .wb_dat_i(32'h0), .wb_dat_o(), .wb_ack_o(), .irq_o());
  sdi_device #(.ACTUATOR_VARIANT(1'b1), .WARN_CYCLES(64'd50), .COMM_TIMEOUT(20))
    sdi_device_var_i(.clk_i(clk_i), .rst_i(rst_i), .power_on_rst_i(por),
    .link(sdi_link_if_var_i), .guard_closed_i(guard), .actuator_in_i(act),
    .lock_engaged_i(lock), .safety_input_one_i(in1), .safety_input_two_i(in2),
    .warn_cause_i(wcause), .err_cause_i(ecause), .safety_output_one_o(vso1),
    .safety_output_two_o(vso2), .magnet_o(), .force_sel_o());
  // short timer so the escalation fits in the run
  sdi_device #(.WARN_CYCLES(64'd50), .COMM_TIMEOUT(20)) sdi_device_i(.clk_i(clk_i),
    .rst_i(rst_i), .power_on_rst_i(por), .link(sdi_link_if_i), .guard_closed_i(guard),
    .actuator_in_i(act), .lock_engaged_i(lock), .safety_input_one_i(in1),
    .safety_input_two_i(in2), .warn_cause_i(wcause), .err_cause_i(ecause),
    .safety_output_one_o(so1), .safety_output_two_o(so2), .magnet_o(mag),
    .force_sel_o(fsel));
  sdi_assertions #(.WARN_CYCLES(50)) sdi_assertions_i(.clk_i(clk_i), .rst_i(rst_i),
    .cmd(sdi_link_if_i.cmd), .cmd_valid(sdi_link_if_i.cmd_valid), .rsp(sdi_link_if_i.rsp),
    .warn(sdi_link_if_i.warn), .err(sdi_link_if_i.err), .rsp_valid(sdi_link_if_i.rsp_valid));
  // -------------------------------------------------------------
  // bus and check tasks
  // -------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), q & m, e);
  endtask
  task automatic settle();
    repeat (12) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    wd++;
    if (wd == 5000) begin
      mismatches++;
      results();
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    por <= 1'b0;
    rc(SDI_REG_CMD, 8'hFF, 8'h00);
    rc(8'h1C, 8'hFF, 8'h00);
    wb(1'b1, SDI_REG_IRQ_EN, 8'h07);
    wb(1'b1, SDI_REG_CMD, 8'h8B);
    {guard, act, lock, in1, in2} <= 5'h1F;
    settle();
    chk("magnet", {7'h00, mag}, 8'h01);
    chk("force", {5'h00, fsel}, 8'h05);
    chk("outs", {6'h00, so1, so2}, 8'h03);
    rc(SDI_REG_RSP, 8'hFF, 8'h17);
    wcause <= 8'h08;
    settle();
    rc(SDI_REG_RSP, 8'hFF, 8'h57);
    rc(SDI_REG_WARN, 8'hFF, 8'h08);
    chk("irq", {7'h00, irq}, 8'h01);
    rc(SDI_REG_IRQ_STAT, 8'h02, 8'h02);
    wb(1'b1, SDI_REG_IRQ_CLR, 8'h07);
    rc(SDI_REG_IRQ_STAT, 8'hFF, 8'h00);
    wb(1'b1, SDI_REG_IRQ_EN, 8'h00);
    wcause <= 8'h00;
    settle();
    rc(SDI_REG_RSP, 8'hFF, 8'h17);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wcause <= 8'h08;
    repeat (80) @(posedge clk_i);
    rc(SDI_REG_RSP, 8'hFF, 8'h96);
    rc(SDI_REG_ERR, 8'hFF, 8'h08);
    chk("outs", {6'h00, so1, so2}, 8'h00);
    wcause <= 8'h00;
    settle();
    rc(SDI_REG_RSP, 8'h80, 8'h80);
    wb(1'b1, SDI_REG_CMD, 8'h0B);
    settle();
    rc(SDI_REG_RSP, 8'hFF, 8'h17);
    ecause <= 8'h10;
    settle();
    rc(SDI_REG_RSP, 8'h81, 8'h80);
    rc(SDI_REG_ERR, 8'hFF, 8'h10);
    ecause <= 8'h00;
    guard <= 1'b0;
    settle();
    rc(SDI_REG_RSP, 8'h80, 8'h00);
    guard <= 1'b1;
    settle();
    rc(SDI_REG_RSP, 8'hFF, 8'h17);
    ecause <= 8'h01;
    settle();
    rc(SDI_REG_RSP, 8'h81, 8'h80);
    ecause <= 8'h00;
    guard <= 1'b0;
    settle();
    guard <= 1'b1;
    settle();
    rc(SDI_REG_ERR, 8'hFF, 8'h01);
    wb(1'b1, SDI_REG_CMD, 8'h8B);
    wb(1'b1, SDI_REG_CMD, 8'h0B);
    settle();
    rc(SDI_REG_RSP, 8'hFF, 8'h17);
    ecause <= 8'h03;
    settle();
    rc(SDI_REG_ERR, 8'h04, 8'h04);
    ecause <= 8'h00;
    wb(1'b1, SDI_REG_CMD, 8'h8B);
    wb(1'b1, SDI_REG_CMD, 8'h0B);
    settle();
    rc(SDI_REG_RSP, 8'h81, 8'h80);
    por <= 1'b1;
    @(posedge clk_i);
    por <= 1'b0;
    settle();
    rc(SDI_REG_RSP, 8'hFF, 8'h17);
    chk("variant outs locked", {6'h00, vso1, vso2}, 8'h03);
    lock <= 1'b0;
    settle();
    rc(SDI_REG_RSP, 8'hFF, 8'h12);
    chk("outs unlocked", {6'h00, so1, so2}, 8'h00);
    chk("variant outs unlocked", {6'h00, vso1, vso2}, 8'h03);
    results();
  end
endmodule
`default_nettype wire
